// ==== tb/bhm_asserts.sv ====
// Concurrent checks on the multiplier and sequencer interface
`timescale 1ns/1ps
module bhm_asserts (
   // Clock and reset
   input wire logic       CLK,
   input wire logic       RST_N,
   // Interface signals
   input wire logic       mul_go,
   input wire logic [7:0] working_register,
   input wire logic [7:0] file_operand,
   input wire logic       prod_wr,
   input wire logic [7:0] product_high_byte,
   input wire logic [7:0] product_low_byte,
   input wire logic [7:0] alu_status_register
);
   logic [15:0] prod_exp;
   logic [15:0] pair;
   assign prod_exp = working_register * file_operand;
   assign pair     = {product_high_byte, product_low_byte};
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////
   a_prod_full: assert property (mul_go |=> pair == $past(prod_exp))
      else $error("Product differs from operands");
   a_high_byte: assert property (mul_go |=>
      product_high_byte == $past(prod_exp[15:8])) else $error("High byte");
   a_low_byte: assert property (mul_go |=>
      product_low_byte == $past(prod_exp[7:0])) else $error("Low byte");
   a_back_to_back: assert property (mul_go ##1 mul_go |=>
      pair == $past(prod_exp)) else $error("Back to back product");
   a_flags_kept: assert property (mul_go |=> $stable(alu_status_register))
      else $error("Status changed by multiply");
   a_pair_holds: assert property (!mul_go && !prod_wr |=> $stable(pair))
      else $error("Product pair changed");
   a_prod_bound: assert property (pair <= 16'hfe01)
      else $error("Product above byte range");
   a_reset_clear: assert property ($rose(RST_N) |-> pair == 16'h0000)
      else $error("Product pair not clear");
endmodule : bhm_asserts

// ==== tb/byte_hardware_multiplier_tb.sv ====
// Self-checking bench for the multiplier and its sequencer
`timescale 1ns/1ps
module byte_hardware_multiplier_tb
   import bhm_pkg::*;
;
   logic        clk;
   logic        rst_n   = 1'b0;
   logic        stat_we = 1'b0;
   logic [7:0]  stat_in = 8'h00;
   logic        start   = 1'b0;
   bhm_op_e     op      = BHM_OP_U8;
   logic [15:0] a       = 16'h0000;
   logic [15:0] b       = 16'h0000;
   logic        done;
   logic        busy;
   logic [31:0] res;
   int          failures    = 0;
   int          checks_done = 0;
   logic [15:0] xs [5] = '{16'h00ff, 16'h0080, 16'hffff, 16'h8000, 16'h0000};
   logic [15:0] ys [5] = '{16'h00ff, 16'h00ff, 16'hffff, 16'h7fff, 16'h1234};
   bhm_if bus ();
   bhm_mult i_bhm_mult (.CLK(clk), .RST_N(rst_n), .BUS(bus.mult),
      .STAT_WE(stat_we), .STAT_IN(stat_in));
   bhm_seq i_bhm_seq (.CLK(clk), .RST_N(rst_n), .BUS(bus.seq), .START(start),
      .OP(op), .FIRST_OPERAND(a), .SECOND_OPERAND(b), .BUSY(busy),
      .DONE(done), .WIDE_RESULT_BYTES(res));
   bhm_asserts i_bhm_asserts (.CLK(clk), .RST_N(rst_n), .mul_go(bus.mul_go),
      .working_register(bus.working_register),
      .file_operand(bus.file_operand), .prod_wr(bus.prod_wr),
      .product_high_byte(bus.product_high_byte),
      .product_low_byte(bus.product_low_byte),
      .alu_status_register(bus.alu_status_register));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] expect_of(bhm_op_e o, logic [15:0] x,
                                             logic [15:0] y);
      logic [15:0] u;
      logic [15:0] s;
      logic [31:0] r;
      u = x[7:0] * y[7:0];
      s = $signed(x[7:0]) * $signed(y[7:0]);
      r = x * y;
      if (o == BHM_OP_S16) r = $signed(x) * $signed(y);
      if (o == BHM_OP_U8) r = {16'h0000, u};
      if (o == BHM_OP_S8) r = {16'h0000, s};
      return r;
   endfunction : expect_of
   task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val
   task automatic wrap_up;
      $display("Checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   task automatic run_op(bhm_op_e o, logic [15:0] x, logic [15:0] y);
      int n;
      @(negedge clk);
      op = o;
      a = x;
      b = y;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      stat_we = 1'b1;
      stat_in = 8'ha5;
      check_val("busy", 32'h1, {31'h0, busy});
      @(negedge clk);
      stat_we = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      check_val("done", 32'h1, {31'h0, done});
      check_val("idle", 32'h0, {31'h0, busy});
      check_val("result", expect_of(o, x, y), res);
      if (o == BHM_OP_U8) check_val("pair", expect_of(o, x, y),
         {16'h0000, bus.product_high_byte, bus.product_low_byte});
   endtask : run_op
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #50000;
      failures++;
      wrap_up();
   end
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      stat_we = 1'b1;
      stat_in = 8'h5a;
      @(negedge clk);
      stat_we = 1'b0;
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < 5; k++) begin
            run_op(bhm_op_e'(i), xs[k], ys[k]);
         end
         $display("Test op %0d finished", i);
      end
      check_val("status", 32'h5a, {24'h0, bus.alu_status_register});
      wrap_up();
   end
endmodule : byte_hardware_multiplier_tb

// ==== verilog/bhm_if.sv ====
// Interface between the multiplier and the instruction sequencer
`timescale 1ns/1ps
interface bhm_if;
   logic       mul_go;
   logic [7:0] working_register;
   logic [7:0] file_operand;
   logic       prod_wr;
   logic [7:0] prod_wr_high;
   logic [7:0] prod_wr_low;
   logic [7:0] product_high_byte;
   logic [7:0] product_low_byte;
   logic [7:0] alu_status_register;

   modport mult (
      input  mul_go, working_register, file_operand,
      input  prod_wr, prod_wr_high, prod_wr_low,
      output product_high_byte, product_low_byte, alu_status_register
   );
   modport seq (
      output mul_go, working_register, file_operand,
      output prod_wr, prod_wr_high, prod_wr_low,
      input  product_high_byte, product_low_byte, alu_status_register
   );
endinterface : bhm_if

// ==== verilog/bhm_mult.sv ====
// Single-cycle 8 by 8 unsigned multiplier with product register pair
`timescale 1ns/1ps
module bhm_mult
   import bhm_pkg::*;
(
   // Clock and reset
   input  wire logic CLK,
   input  wire logic RST_N,
   // Sequencer side
   bhm_if.mult       BUS,
   // Status flags written by the rest of the ALU
   input  wire logic       STAT_WE,
   input  wire logic [7:0] STAT_IN
);
   logic [7:0] prod_hi_r;
   logic [7:0] prod_lo_r;
   logic [7:0] stat_r;
   logic [15:0] prod_nxt;

   ////////////////////////////////////////////////////////////////////
   // Full unsigned product, no truncation
   always_comb begin
      prod_nxt = 16'(BUS.working_register) * 16'(BUS.file_operand);
   end

   // Product pair: written by multiply, else by software, else held
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         prod_hi_r <= BHM_BYTE_RST;
         prod_lo_r <= BHM_BYTE_RST;
      end else if (BUS.mul_go) begin
         prod_hi_r <= prod_nxt[15:8];
         prod_lo_r <= prod_nxt[7:0];
      end else if (BUS.prod_wr) begin
         prod_hi_r <= BUS.prod_wr_high;
         prod_lo_r <= BUS.prod_wr_low;
      end
   end

   // Status flags never touched by a multiply
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         stat_r <= BHM_STAT_RST;
      end else if (STAT_WE && !BUS.mul_go) begin
         stat_r <= STAT_IN;
      end
   end

   assign BUS.product_high_byte   = prod_hi_r;
   assign BUS.product_low_byte    = prod_lo_r;
   assign BUS.alu_status_register = stat_r;
endmodule : bhm_mult

// ==== verilog/bhm_pkg.sv ====
// Package for the byte hardware multiplier and its sequencer
package bhm_pkg;
   localparam int BHM_OP_W     = 8;
   localparam int BHM_PROD_W   = 16;
   localparam int BHM_WIDE_W   = 32;
   localparam int BHM_MUL_CYC  = 1;
   localparam logic [7:0]  BHM_BYTE_RST = 8'h00;
   localparam logic [31:0] BHM_WIDE_RST = 32'h0000_0000;
   localparam logic [7:0]  BHM_STAT_RST = 8'h00;
   localparam int BHM_SIGN_BIT = 7;

   // Sequencer operations
   typedef enum logic [1:0] {
      BHM_OP_U8  = 2'b00,
      BHM_OP_S8  = 2'b01,
      BHM_OP_U16 = 2'b10,
      BHM_OP_S16 = 2'b11
   } bhm_op_e;
endpackage : bhm_pkg

// ==== verilog/bhm_seq.sv ====
// Sequencer building signed and wide products from byte multiplies
`timescale 1ns/1ps
module bhm_seq
   import bhm_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // Multiplier side
   bhm_if.seq               BUS,
   // Request
   input  wire logic        START,
   input  wire bhm_op_e     OP,
   input  wire logic [15:0] FIRST_OPERAND,
   input  wire logic [15:0] SECOND_OPERAND,
   // Answer
   output logic             BUSY,
   output logic             DONE,
   output logic [31:0]      WIDE_RESULT_BYTES
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LL   = 3'b001,
      ST_HH   = 3'b010,
      ST_LH   = 3'b011,
      ST_HL   = 3'b100,
      ST_ACC  = 3'b101,
      ST_SIGN = 3'b110
   } bhm_st_e;

   bhm_st_e     st_r;
   bhm_st_e     st_nxt;
   bhm_op_e     op_r;
   logic [15:0] a_r;
   logic [15:0] b_r;
   logic [31:0] res_r;
   logic        go_r;
   logic [7:0]  wa_r;
   logic [7:0]  fb_r;
   logic        busy_r;
   logic        done_r;
   logic [15:0] prod;

   function automatic logic [7:0] pick(input logic [15:0] v,
                                       input logic hi);
      pick = hi ? v[15:8] : v[7:0];
   endfunction : pick

   assign prod = {BUS.product_high_byte, BUS.product_low_byte};

   ////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (START) begin
               st_nxt = ST_LL;
            end
         end
         ST_LL: begin
            st_nxt = op_r[1] ? ST_HH : ST_SIGN;
         end
         ST_HH: begin
            st_nxt = ST_LH;
         end
         ST_LH: begin
            st_nxt = ST_HL;
         end
         ST_HL: begin
            st_nxt = ST_ACC;
         end
         ST_ACC: begin
            st_nxt = ST_SIGN;
         end
         ST_SIGN: begin
            st_nxt = ST_IDLE;
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_r <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Capture request
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         op_r <= BHM_OP_U8;
         a_r  <= 16'h0000;
         b_r  <= 16'h0000;
      end else if (st_r == ST_IDLE && START) begin
         op_r <= OP;
         a_r  <= FIRST_OPERAND;
         b_r  <= SECOND_OPERAND;
      end
   end

   // Issue multiplies: working register and file operand
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         go_r <= 1'b0;
         wa_r <= BHM_BYTE_RST;
         fb_r <= BHM_BYTE_RST;
      end else begin
         go_r <= 1'b0;
         case (st_nxt)
            ST_LL: begin
               go_r <= 1'b1;
               wa_r <= (st_r == ST_IDLE) ? FIRST_OPERAND[7:0] : wa_r;
               fb_r <= (st_r == ST_IDLE) ? SECOND_OPERAND[7:0] : fb_r;
            end
            ST_HH: begin
               go_r <= 1'b1;
               wa_r <= pick(a_r, 1'b1);
               fb_r <= pick(b_r, 1'b1);
            end
            ST_LH: begin
               go_r <= 1'b1;
               wa_r <= pick(a_r, 1'b0);
               fb_r <= pick(b_r, 1'b1);
            end
            ST_HL: begin
               go_r <= 1'b1;
               wa_r <= pick(a_r, 1'b1);
               fb_r <= pick(b_r, 1'b0);
            end
            default: begin
               go_r <= 1'b0;
            end
         endcase
      end
   end

   // Accumulate result; product pair valid the cycle after go
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         res_r <= BHM_WIDE_RST;
      end else begin
         case (st_r)
            ST_HH: begin
               res_r <= {16'h0000, prod};
            end
            ST_LH: begin
               res_r <= {prod, res_r[15:0]};
            end
            ST_HL, ST_ACC: begin
               res_r <= res_r + {8'h00, prod, 8'h00};
            end
            ST_SIGN: begin
               if (op_r == BHM_OP_U8) begin
                  res_r <= {16'h0000, prod};
               end else if (op_r == BHM_OP_S8) begin
                  res_r <= {16'h0000,
                     prod[15:8]
                     - (b_r[BHM_SIGN_BIT] ? a_r[7:0] : 8'h00)
                     - (a_r[BHM_SIGN_BIT] ? b_r[7:0] : 8'h00),
                     prod[7:0]};
               end else if (op_r == BHM_OP_S16) begin
                  res_r <= {res_r[31:16]
                     - (b_r[15] ? a_r : 16'h0000)
                     - (a_r[15] ? b_r : 16'h0000),
                     res_r[15:0]};
               end
            end
            default: begin
               res_r <= res_r;
            end
         endcase
      end
   end

   // Handshake outputs
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         busy_r <= (st_nxt != ST_IDLE);
         done_r <= (st_r == ST_SIGN);
      end
   end

   assign BUS.mul_go           = go_r;
   assign BUS.working_register = wa_r;
   assign BUS.file_operand     = fb_r;
   assign BUS.prod_wr          = 1'b0;
   assign BUS.prod_wr_high     = BHM_BYTE_RST;
   assign BUS.prod_wr_low      = BHM_BYTE_RST;
   assign BUSY                 = busy_r;
   assign DONE                 = done_r;
   assign WIDE_RESULT_BYTES    = res_r;
endmodule : bhm_seq
